// file: design/sbs_consts.vh
// Purpose: constants for the serial baud and status block
// Assumes: APB, 32-bit data, one word per register
// Notes: byte address is four times the register index
`ifndef SBS_CONSTS_VH
`define SBS_CONSTS_VH
`define SBS_IDX_BAUD 4'h2
`define SBS_IDX_STATUS 4'h3
`define SBS_IDX_DATA 4'h5
`define SBS_IDX_CTRL 4'h8
`define SBS_IDX_IRQST 4'h9
`define SBS_IDX_IRQMASK 4'ha
`define SBS_BAUD_RESET 8'h04
`define SBS_STATUS_RESET 8'h20
`define SBS_ST_RXF 7
`define SBS_ST_WRITE_COLLISION_FLAG 6
`define SBS_ST_TXE 5
`define SBS_ST_MODE_FAULT_FLAG 4
`define SBS_CTRL_TXIE 0
`define SBS_IRQ_RX 0
`define SBS_IRQ_TX 1
`define SBS_DIV_W 12
`endif

// file: design/sbs_baud_gen.v
// Purpose: serial bit clock divider
// Assumes: one clock, asynchronous active-high reset
// Notes: tick every divisor cycles; sclk toggles at half points
`timescale 1ns/1ps
`include "sbs_consts.vh"
module sbs_baud_gen (
  input wire clk,
  input wire rst,
  input wire [2:0] prescaleSelect,
  input wire [2:0] rateSelect,
  output reg bitTick,
  output reg sclkOut
);
  reg [`SBS_DIV_W-1:0] count_reg;
  wire [`SBS_DIV_W-1:0] divisor;
  // Divisor (p+1) * 2^(r+1), largest 8*256 fits in 12 bits
  assign divisor = {9'h000, prescaleSelect + 3'h0} + 12'h001 << (rateSelect + 4'h1);
  wire [`SBS_DIV_W-1:0] half;
  assign half = {1'b0, divisor[`SBS_DIV_W-1:1]};
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      count_reg <= 12'h000;
      bitTick <= 1'b0;
      sclkOut <= 1'b0;
    end else begin
      bitTick <= 1'b0;
      if (count_reg >= divisor - 12'h001) begin
        count_reg <= 12'h000;
        bitTick <= 1'b1;
        sclkOut <= 1'b0;
      end else begin
        count_reg <= count_reg + 12'h001;
        if (count_reg == half - 12'h001)
          sclkOut <= 1'b1;
      end
    end
  end
endmodule // sbs_baud_gen

// file: design/sbs_serial_status.v
// Purpose: baud register, status flags and byte exchange
// Assumes: APB slave, zero wait states, serial lines from pins
// Notes: master-mode shifter, MSB first, mode 0 only
`timescale 1ns/1ps
`include "sbs_consts.vh"
// Notes on behaviour
// - Bit clock divisor from prescale and rate
// - Baud fields bits 6:4, 2:0; 7,3 zero
// - Set receive flag when byte reaches data
// - Clear receive flag: status read, data read
// - Receive flag one means new data
// - Set transmit-empty flag on buffer handoff
// - No collision flag; bit reads zero
// - Transmit interrupt when empty flag sets
module sbs_serial_status (
  input wire clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  output reg irq,
  output reg sclk,
  output reg mosi,
  input wire miso
);
  reg [7:0] baud_reg;
  reg rxFlag_reg;
  reg txEmpty_reg;
  reg rxArm_reg;
  reg txArm_reg;
  reg [7:0] rxData_reg;
  reg [7:0] txBuf_reg;
  reg [7:0] shift_reg;
  reg [3:0] bitCnt_reg;
  reg busy_reg;
  reg ctrl_reg;
  reg [1:0] irqSt_reg;
  reg [1:0] irqMask_reg;
  reg [2:0] misoSync_reg;
  reg sclkPrev_reg;
  reg misoLevel_reg;
  wire tick;
  wire sclkRaw;
  localparam IDLE = 1'b0;
  localparam SHIFT = 1'b1;

  function [3:0] regIndex;
    input [11:0] a;
    regIndex = a[5:2];
  endfunction

  function inMap;
    input [11:0] a;
    inMap = (a[11:6] == 6'h00) && (a[1:0] == 2'b00);
  endfunction

  wire access = psel && penable;
  wire wrEn = access && pwrite && inMap(paddr);
  wire rdEn = access && !pwrite && inMap(paddr);
  wire [3:0] idx = regIndex(paddr);
  wire statusRd = rdEn && idx == `SBS_IDX_STATUS;
  wire dataRd = rdEn && idx == `SBS_IDX_DATA;
  wire dataWr = wrEn && idx == `SBS_IDX_DATA;
  wire [7:0] statusVal = {rxFlag_reg, 1'b0, txEmpty_reg, 1'b0, 4'h0};

  sbs_baud_gen u_baud (
    .clk(clk),
    .rst(rst),
    .prescaleSelect(baud_reg[6:4]),
    .rateSelect(baud_reg[2:0]),
    .bitTick(tick),
    .sclkOut(sclkRaw)
  );

  // Receive completes on the last bit; handoff starts a new byte
  wire byteDone = busy_reg && tick && bitCnt_reg == 4'h7;
  wire loadShift = tick && !txEmpty_reg && (!busy_reg || byteDone);
  wire rxSet = byteDone;
  wire txSet = loadShift;

  // Sample MISO on sclk rising; filtered level from stages 2 and 3
  // Filter lags about four clocks, so half a bit must be longer
  wire misoStable = misoSync_reg[2] == misoSync_reg[1];
  wire sampleEdge = sclkRaw && !sclkPrev_reg;
  wire irqClrWr = wrEn && idx == `SBS_IDX_IRQST;
  wire setupCycle = psel && !penable;

  reg rxBit_reg;
  reg rxFlag_next;
  reg txEmpty_next;
  reg rxArm_next;
  reg txArm_next;
  reg [7:0] rxData_next;
  reg [7:0] txBuf_next;
  reg busy_next;
  reg [7:0] shift_next;
  reg [3:0] bitCnt_next;
  reg rxBit_next;
  reg mosi_next;
  reg [1:0] irqSt_next;
  reg [31:0] prdata_next;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      misoSync_reg <= 3'b000;
      misoLevel_reg <= 1'b0;
      sclkPrev_reg <= 1'b0;
    end else begin
      misoSync_reg <= {misoSync_reg[1:0], miso};
      if (misoStable)
        misoLevel_reg <= misoSync_reg[2];
      sclkPrev_reg <= sclkRaw;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      baud_reg <= `SBS_BAUD_RESET;
      ctrl_reg <= 1'b0;
      irqMask_reg <= 2'b00;
    end else if (wrEn) begin
      if (idx == `SBS_IDX_BAUD)
        baud_reg <= {1'b0, pwdata[6:4], 1'b0, pwdata[2:0]};
      else if (idx == `SBS_IDX_CTRL)
        ctrl_reg <= pwdata[`SBS_CTRL_TXIE];
      else if (idx == `SBS_IDX_IRQMASK)
        irqMask_reg <= pwdata[1:0];
    end
  end

  // Flags: hardware set wins over the software clear sequence
  always @* begin
    rxArm_next = rxArm_reg;
    txArm_next = txArm_reg;
    rxFlag_next = rxFlag_reg;
    txEmpty_next = txEmpty_reg;
    rxData_next = rxData_reg;
    txBuf_next = txBuf_reg;
    if (statusRd) begin
      rxArm_next = rxFlag_reg;
      txArm_next = txEmpty_reg;
    end else begin
      if (dataRd)
        rxArm_next = 1'b0;
      if (dataWr)
        txArm_next = 1'b0;
    end
    if (rxSet) begin
      rxFlag_next = 1'b1;
      rxData_next = {shift_reg[6:0], rxBit_reg};
    end else if (dataRd && rxArm_reg) begin
      rxFlag_next = 1'b0;
    end
    if (txSet)
      txEmpty_next = 1'b1;
    else if (dataWr && txArm_reg)
      txEmpty_next = 1'b0;
    // Data write without the status read is dropped
    if (dataWr && txArm_reg)
      txBuf_next = pwdata[7:0];
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rxFlag_reg <= 1'b0;
      txEmpty_reg <= 1'b1;
      rxArm_reg <= 1'b0;
      txArm_reg <= 1'b0;
      txBuf_reg <= 8'h00;
      rxData_reg <= 8'h00;
    end else begin
      rxFlag_reg <= rxFlag_next;
      txEmpty_reg <= txEmpty_next;
      rxArm_reg <= rxArm_next;
      txArm_reg <= txArm_next;
      txBuf_reg <= txBuf_next;
      rxData_reg <= rxData_next;
    end
  end

  // Outgoing bits leave at the top, received bits enter at the bottom
  always @* begin
    busy_next = busy_reg;
    shift_next = shift_reg;
    bitCnt_next = bitCnt_reg;
    rxBit_next = rxBit_reg;
    mosi_next = mosi;
    case (busy_reg)
      IDLE: begin
        if (loadShift) begin
          busy_next = SHIFT;
          shift_next = txBuf_reg;
          mosi_next = txBuf_reg[7];
          bitCnt_next = 4'h0;
        end
      end
      SHIFT: begin
        // Held apart so bit 0 of the outgoing byte is not overwritten
        if (sampleEdge)
          rxBit_next = misoLevel_reg;
        if (loadShift) begin
          shift_next = txBuf_reg;
          mosi_next = txBuf_reg[7];
          bitCnt_next = 4'h0;
        end else if (byteDone) begin
          busy_next = IDLE;
        end else if (tick) begin
          shift_next = {shift_reg[6:0], rxBit_reg};
          mosi_next = shift_reg[6];
          bitCnt_next = bitCnt_reg + 4'h1;
        end
      end
      default: begin
        busy_next = IDLE;
      end
    endcase
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_reg <= IDLE;
      shift_reg <= 8'h00;
      bitCnt_reg <= 4'h0;
      rxBit_reg <= 1'b0;
      mosi <= 1'b0;
      sclk <= 1'b0;
    end else begin
      busy_reg <= busy_next;
      shift_reg <= shift_next;
      bitCnt_reg <= bitCnt_next;
      rxBit_reg <= rxBit_next;
      mosi <= mosi_next;
      // Clock held low between bytes
      sclk <= busy_reg ? sclkRaw : 1'b0;
    end
  end

  // Interrupt status, write one to clear; set wins
  always @* begin
    irqSt_next = irqSt_reg;
    if (irqClrWr && pwdata[`SBS_IRQ_RX])
      irqSt_next[`SBS_IRQ_RX] = 1'b0;
    if (irqClrWr && pwdata[`SBS_IRQ_TX])
      irqSt_next[`SBS_IRQ_TX] = 1'b0;
    if (rxSet)
      irqSt_next[`SBS_IRQ_RX] = 1'b1;
    if (txSet && ctrl_reg)
      irqSt_next[`SBS_IRQ_TX] = 1'b1;
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      irqSt_reg <= 2'b00;
      irq <= 1'b0;
    end else begin
      irqSt_reg <= irqSt_next;
      irq <= |(irqSt_reg & irqMask_reg);
    end
  end

  // Read data formed in setup so it stands in the access cycle
  always @* begin
    prdata_next = 32'h00000000;
    if (setupCycle && !pwrite && inMap(paddr)) begin
      if (idx == `SBS_IDX_BAUD)
        prdata_next = {24'h000000, baud_reg};
      else if (idx == `SBS_IDX_STATUS)
        prdata_next = {24'h000000, statusVal};
      else if (idx == `SBS_IDX_DATA)
        prdata_next = {24'h000000, rxData_reg};
      else if (idx == `SBS_IDX_CTRL)
        prdata_next = {31'h00000000, ctrl_reg};
      else if (idx == `SBS_IDX_IRQST)
        prdata_next = {30'h00000000, irqSt_reg};
      else if (idx == `SBS_IDX_IRQMASK)
        prdata_next = {30'h00000000, irqMask_reg};
    end
  end

  // Every transfer answers in its first access cycle
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setupCycle;
      pslverr <= setupCycle && !inMap(paddr);
      prdata <= prdata_next;
    end
  end
endmodule // sbs_serial_status

// file: testbench/sbs_monitor.sv
// Purpose: port checks of sbs_serial_status
// Assumes: one-cycle APB answer
// Notes: bound at file foot
`timescale 1ns/1ps
module sbs_monitor (
  input wire clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire irq,
  input wire sclk,
  input wire mosi
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_rdy; psel && !penable |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("no answer");
  property p_one; pready |=> !pready; endproperty
  a_one: assert property (p_one) else $error("long answer");
  property p_err; psel && !penable && paddr[11:6] != 6'h00 |=> pslverr && prdata == 32'h0; endproperty
  a_err: assert property (p_err) else $error("unmapped accepted");
  property p_errq; pslverr |-> pready; endproperty
  a_errq: assert property (p_errq) else $error("stray error");
  property p_baud; pready && !pwrite && paddr == 12'h008 |-> prdata[31:8] == 24'h0 && !prdata[7] && !prdata[3];
  endproperty
  a_baud: assert property (p_baud) else $error("baud spare bits");
  property p_stat; pready && !pwrite && paddr == 12'h00c |-> !prdata[6] && !prdata[4]; endproperty
  a_stat: assert property (p_stat) else $error("status spare bits");
  property p_irq; psel && penable && pwrite && paddr == 12'h024 && pwdata[1:0] == 2'h3 |-> ##2 !irq; endproperty
  a_irq: assert property (p_irq) else $error("irq stuck");
  property p_mosi; $rose(sclk) |-> $stable(mosi); endproperty
  a_mosi: assert property (p_mosi) else $error("data moved at sample");
  c_irq: cover property ($rose(irq));
  c_err: cover property (pslverr);
  c_sclk: cover property ($rose(sclk));
endmodule // sbs_monitor
bind sbs_serial_status sbs_monitor u_mon (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .sclk(sclk),
  .mosi(mosi));

// file: testbench/sbs_spi_peer.sv
// Purpose: serial slave beside the block
// Assumes: mode 0, MSB first
// Notes: byte preloaded by load
`timescale 1ns/1ps
module sbs_spi_peer (
  input wire sclk,
  input wire mosi,
  input wire load,
  input wire [7:0] txByte,
  output logic miso,
  output logic [7:0] rxByte
);
  logic [7:0] sh = 8'h00;
  initial rxByte = 8'h00;
  assign miso = sh[7];
  // Spent bits come back inverted so a stale sample cannot match
  always @(negedge sclk or posedge load) begin
    if (load) sh <= txByte;
    else sh <= {sh[6:0], ~sh[7]};
  end
  always @(posedge sclk) rxByte <= {rxByte[6:0], mosi};
endmodule // sbs_spi_peer

// file: testbench/tb_top.sv
// Purpose: self-checking bench of sbs_serial_status
// Assumes: APB answer with pready
// Notes: reads checked from a queue
`timescale 1ns/1ps
module tb_top;
  logic clk, rst, psel, penable, pwrite, load, pready, pslverr, irq, sclk, mosi, miso;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0] rxB, b, r;
  logic [32:0] q[$];
  int err_total, cmp_count, n, k;
  sbs_serial_status DUT (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .sclk(sclk), .mosi(mosi),
    .miso(miso));
  sbs_spi_peer peer (.sclk(sclk), .mosi(mosi), .load(load), .txByte(r), .miso(miso), .rxByte(rxB));
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  task chk(input logic [32:0] got, input logic [32:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task complete_run;
    $display("compares %0d errors %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 50 && pready !== 1'b1; n++) @(posedge clk);
    if (n == 50) begin
      err_total++;
      complete_run;
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task rd(input logic [11:0] a, input logic [32:0] x);
    q.push_back(x);
    apb(1'b0, a, 32'h0);
  endtask
  task wirq;
    for (k = 0; k < 3000 && irq !== 1'b1; k++) @(posedge clk);
    if (k == 3000) begin
      err_total++;
      complete_run;
    end
  endtask
  always @(posedge clk) begin
    if (psel && penable && pready && !pwrite) chk({pslverr, prdata}, q.pop_front());
  end
  initial begin
    {rst, psel, penable, pwrite, load, paddr, pwdata, r} = {5'h10, 12'h0, 32'h0, 8'h0};
    b = 8'($urandom(32'hdb4b));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(12'h008, 33'h04);
    rd(12'h00c, 33'h20);
    rd(12'h040, {1'b1, 32'h0});
    apb(1'b1, 12'h008, 32'hff);
    rd(12'h008, 33'h77);
    $display("register test done");
    apb(1'b1, 12'h008, 32'h22);
    apb(1'b1, 12'h020, 32'h1);
    apb(1'b1, 12'h028, 32'h3);
    b = 8'($urandom);
    r = 8'($urandom);
    load <= 1'b1;
    @(posedge clk);
    load <= 1'b0;
    rd(12'h00c, 33'h20);
    apb(1'b1, 12'h014, {24'h0, b});
    wirq;
    rd(12'h024, 33'h2);
    apb(1'b1, 12'h024, 32'h3);
    for (k = 0; k < 99 && sclk !== 1'b1; k++) @(posedge clk);
    for (k = 0; k < 99 && sclk !== 1'b0; k++) @(posedge clk);
    for (k = 0; k < 99 && sclk !== 1'b1; k++) @(posedge clk);
    for (k = 0; k < 99 && sclk !== 1'b0; k++) @(posedge clk);
    for (; k < 99 && sclk !== 1'b1; k++) @(posedge clk);
    chk(33'(k), 33'd24);
    wirq;
    rd(12'h024, 33'h1);
    rd(12'h00c, 33'ha0);
    rd(12'h014, {25'h0, r});
    rd(12'h00c, 33'h20);
    chk({25'h0, rxB}, {25'h0, b});
    apb(1'b1, 12'h024, 32'h3);
    $display("transfer test done");
    complete_run;
  end
endmodule // tb_top
